// ==== rtl/plp_param_loader.sv ====
// parameter load command parser: fetches a command block from host memory,
// checks it, copies double-word parameters into the parameter table and
// writes a status word back
// assumes the host memory port runs on CLK and answers each request with MEM_ACK
// Function
// - header sits in command words one to ten
// - memory type codes 46h 48h 08h 0Ah 0Ch
// - discrete status word spans sixteen consecutive bits
// - status offset word four is zero-based
// - timeout words five and six are ignored
// - command code E501 selects parameter load
// - discrete data: 32 bits per parameter
// - data offset word ten is zero-based
// - starting parameter number ranges 0 to 255
// - each parameter is two consecutive words
// - successive double words fill successive table entries
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "plp_cfg.svh"

module plp_param_loader (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic MEM_REQ,
  output plp_pkg::plp_mem_cmd_t MEM_CMD,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  output logic IRQ
);
  import plp_pkg::*;

  logic rst_s1_q, rst_n;
  plp_state_t state_q;
  logic [5:0] idx_q;
  logic [15:0] hdr_q [0:9];
  logic [15:0] ptr_q, start16_q, lo_q, result_q, step, chk_res;
  logic [7:0] type_q, start_q, tbl_waddr, tbl_idx, cmd_type;
  logic [4:0] count_q;
  logic [15:0] cmd_off;
  logic req_q, ack, done_q, err_q, start, tbl_we, span_bad;
  logic [31:0] tbl_q [0:255];

  // reset enters asynchronously but is released on the clock
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  plp_axil_regs u_regs (
    .clk(CLK),
    .rst_n(rst_n),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .start(start),
    .cmd_type(cmd_type),
    .cmd_off(cmd_off),
    .tbl_idx(tbl_idx),
    .tbl_rdata(tbl_q[tbl_idx]),
    .busy(state_q != PLP_IDLE),
    .result(result_q),
    .ev_done(done_q),
    .ev_err(err_q),
    .irq(IRQ)
  );

  assign ack = MEM_ACK && req_q;
  assign step = plp_mtype_disc(type_q) ? `PLP_STEP_DISC : `PLP_STEP_WORD;

  always_comb begin
    chk_res = `PLP_RES_OK;
    if (hdr_q[`PLP_W_LEN] != `PLP_HDR_LEN) begin
      chk_res = `PLP_RES_LEN;
    end else if (hdr_q[`PLP_W_WAIT] != 16'h0000) begin
      chk_res = `PLP_RES_WAIT;
    end else if (hdr_q[`PLP_W_CODE] != `PLP_CMD_LOAD) begin
      chk_res = `PLP_RES_CODE;
    end else if (hdr_q[`PLP_W_DTYPE][15:8] != 8'h00 ||
                 !plp_mtype_ok(hdr_q[`PLP_W_DTYPE][7:0])) begin
      chk_res = `PLP_RES_MTYPE;
    end
  end

  // start and count must keep every entry inside the table
  assign span_bad = (start16_q > `PLP_START_MAX) || (MEM_RDATA == 16'h0000) ||
    (MEM_RDATA > `PLP_COUNT_MAX) ||
    (({1'b0, start16_q} + {1'b0, MEM_RDATA}) > `PLP_TBL_SIZE);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PLP_IDLE;
      idx_q <= 6'h00;
      ptr_q <= 16'h0000;
      type_q <= 8'h00;
      start16_q <= 16'h0000;
      start_q <= 8'h00;
      count_q <= 5'h00;
      lo_q <= 16'h0000;
      result_q <= 16'h0000;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      unique case (state_q)
        PLP_IDLE: begin
          if (start && plp_mtype_ok(cmd_type)) begin
            type_q <= cmd_type;
            ptr_q <= cmd_off;
            idx_q <= 6'h00;
            state_q <= PLP_HDR;
          end else if (start) begin
            result_q <= `PLP_RES_MTYPE;
            done_q <= 1'b1;
            err_q <= 1'b1;
          end
        end
        // ten header words fetched in order
        PLP_HDR: begin
          if (ack) begin
            ptr_q <= ptr_q + step;
            if (idx_q == `PLP_HDR_LAST) begin
              state_q <= PLP_CHK;
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end
        end
        // timeout words never reach the decision
        PLP_CHK: begin
          idx_q <= 6'h00;
          if (chk_res == `PLP_RES_OK) begin
            type_q <= hdr_q[`PLP_W_DTYPE][7:0];
            ptr_q <= hdr_q[`PLP_W_DOFF];
            state_q <= PLP_SPEC;
          end else begin
            // status location taken as a zero-based offset
            type_q <= hdr_q[`PLP_W_STYPE][7:0];
            ptr_q <= hdr_q[`PLP_W_SOFF];
            result_q <= chk_res;
            state_q <= PLP_STAT;
          end
        end
        // specifier words start at the zero-based data offset
        PLP_SPEC: begin
          if (ack) begin
            ptr_q <= ptr_q + step;
            if (idx_q == 6'h00) begin
              start16_q <= MEM_RDATA;
              start_q <= MEM_RDATA[7:0];
              idx_q <= 6'h01;
            end else if (span_bad) begin
              type_q <= hdr_q[`PLP_W_STYPE][7:0];
              ptr_q <= hdr_q[`PLP_W_SOFF];
              result_q <= `PLP_RES_SPAN;
              state_q <= PLP_STAT;
            end else begin
              count_q <= MEM_RDATA[4:0];
              idx_q <= 6'h00;
              state_q <= PLP_DATA;
            end
          end
        end
        // low word first, then high word of each parameter
        PLP_DATA: begin
          if (ack) begin
            ptr_q <= ptr_q + step;
            if (!idx_q[0]) begin
              lo_q <= MEM_RDATA;
            end
            if (idx_q == {count_q, 1'b0} - 6'h01) begin
              type_q <= hdr_q[`PLP_W_STYPE][7:0];
              ptr_q <= hdr_q[`PLP_W_SOFF];
              result_q <= `PLP_RES_OK;
              state_q <= PLP_STAT;
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end
        end
        // an illegal status location cannot be written, so only the events and the status register report
        PLP_STAT: begin
          if (ack || !plp_mtype_ok(type_q)) begin
            state_q <= PLP_IDLE;
            done_q <= 1'b1;
            err_q <= result_q != `PLP_RES_OK;
          end
        end
        default: state_q <= PLP_IDLE;
      endcase
    end
  end

  // one idle cycle after every acknowledge keeps each request distinct
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
    end else if (ack) begin
      req_q <= 1'b0;
    end else if (!req_q) begin
      req_q <= (state_q == PLP_HDR) || (state_q == PLP_SPEC) || (state_q == PLP_DATA) ||
        ((state_q == PLP_STAT) && plp_mtype_ok(type_q));
    end
  end

  always_ff @(posedge CLK) begin
    if (state_q == PLP_HDR && ack) begin
      hdr_q[idx_q[3:0]] <= MEM_RDATA;
    end
  end

  // double word goes to start plus parameter index
  assign tbl_we = (state_q == PLP_DATA) && ack && idx_q[0];
  assign tbl_waddr = start_q + {3'h0, idx_q[5:1]};

  always_ff @(posedge CLK) begin
    if (tbl_we) begin
      tbl_q[tbl_waddr] <= {MEM_RDATA, lo_q};
    end
  end

  assign MEM_REQ = req_q;
  assign MEM_CMD.we = state_q == PLP_STAT;
  assign MEM_CMD.mtype = type_q;
  assign MEM_CMD.addr = ptr_q;
  assign MEM_CMD.wdata = result_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_data_ack;
    state_q == PLP_DATA && ack;
  endsequence

  sequence s_next_req;
    !MEM_REQ ##1 MEM_REQ;
  endsequence

  a_hdr_fetch_addr: assert property (
    (state_q == PLP_HDR && MEM_REQ) |-> MEM_CMD.addr == cmd_off + {10'h0, idx_q} * step)
    else $error("header word fetched from wrong address");

  a_mtype_legal: assert property (
    MEM_REQ |-> plp_mtype_ok(MEM_CMD.mtype))
    else $error("request made with illegal memory type");

  a_disc_step: assert property (
    (s_data_ack and plp_mtype_disc(type_q)) ##1 (state_q == PLP_DATA)[*1] ##0 s_next_req
      |-> MEM_CMD.addr == $past(MEM_CMD.addr, 2) + 16'h0010)
    else $error("discrete data not advanced by sixteen bits");

  a_word_step: assert property (
    (s_data_ack and !plp_mtype_disc(type_q)) ##1 (state_q == PLP_DATA) ##0 s_next_req
      |-> MEM_CMD.addr == $past(MEM_CMD.addr, 2) + 16'h0001)
    else $error("word data not advanced by one word");

  a_status_loc: assert property (
    (state_q == PLP_STAT && MEM_REQ) |->
      MEM_CMD.we && MEM_CMD.addr == hdr_q[`PLP_W_SOFF] &&
      MEM_CMD.mtype == hdr_q[`PLP_W_STYPE][7:0])
    else $error("status word written to wrong location");

  a_bad_code: assert property (
    (state_q == PLP_CHK && hdr_q[`PLP_W_LEN] == `PLP_HDR_LEN &&
     hdr_q[`PLP_W_WAIT] == 16'h0000 && hdr_q[`PLP_W_CODE] != `PLP_CMD_LOAD)
      |=> state_q == PLP_STAT && result_q == `PLP_RES_CODE)
    else $error("unknown command code not rejected");

  a_timeout_ignored: assert property (
    (state_q == PLP_CHK && hdr_q[`PLP_W_LEN] == `PLP_HDR_LEN &&
     hdr_q[`PLP_W_WAIT] == 16'h0000 && hdr_q[`PLP_W_CODE] == `PLP_CMD_LOAD &&
     hdr_q[`PLP_W_DTYPE] == {8'h00, `PLP_MT_REG}) |=> state_q == PLP_SPEC)
    else $error("valid header refused");

  a_reject_no_write: assert property (
    tbl_we |-> chk_res == `PLP_RES_OK && ({1'b0, start16_q} + {12'h0, count_q}) <= `PLP_TBL_SIZE)
    else $error("table written by a rejected block");

  a_table_target: assert property (
    tbl_we |-> {1'b0, tbl_waddr} == {1'b0, start_q} + {4'h0, idx_q[5:1]} &&
      idx_q[5:1] < count_q && tbl_waddr >= start_q)
    else $error("parameter written to wrong entry");

  a_span_check: assert property (
    (state_q == PLP_SPEC && ack && idx_q == 6'h01 && span_bad)
      |=> state_q == PLP_STAT ##1 !tbl_we)
    else $error("out of range span accepted");

  a_req_hold: assert property (
    (MEM_REQ && !MEM_ACK) |=> MEM_REQ && $stable(MEM_CMD))
    else $error("request dropped or changed before acknowledge");

endmodule

`default_nettype wire

// ==== rtl/plp_cfg.svh ====
// offsets, field positions, reset values and codes of the parameter load parser
// assumes inclusion by bare name from the package and design files
`ifndef PLP_CFG_SVH
`define PLP_CFG_SVH

`define PLP_OFF_CTRL 8'h00
`define PLP_OFF_CMD_LOC 8'h04
`define PLP_OFF_STATUS 8'h08
`define PLP_OFF_IRQ_STAT 8'h0C
`define PLP_OFF_IRQ_MASK 8'h10
`define PLP_OFF_TBL_IDX 8'h14
`define PLP_OFF_TBL_DATA 8'h18

`define PLP_RST_CMD_LOC 32'h0000_0008
`define PLP_RST_IRQ_MASK 2'h0
`define PLP_RST_TBL_IDX 8'h00

`define PLP_HDR_LEN 16'h0004
`define PLP_CMD_LOAD 16'hE501
`define PLP_HDR_LAST 6'h09
`define PLP_W_LEN 4'h0
`define PLP_W_WAIT 4'h1
`define PLP_W_STYPE 4'h2
`define PLP_W_SOFF 4'h3
`define PLP_W_CODE 4'h6
`define PLP_W_DTYPE 4'h8
`define PLP_W_DOFF 4'h9

`define PLP_MT_DISC_IN 8'h46
`define PLP_MT_DISC_OUT 8'h48
`define PLP_MT_REG 8'h08
`define PLP_MT_AIN 8'h0A
`define PLP_MT_AOUT 8'h0C

`define PLP_STEP_DISC 16'h0010
`define PLP_STEP_WORD 16'h0001
`define PLP_START_MAX 16'h00FF
`define PLP_COUNT_MAX 16'h0010
`define PLP_TBL_SIZE 17'h00100

`define PLP_RES_OK 16'h0001
`define PLP_RES_CODE 16'h0002
`define PLP_RES_WAIT 16'h0003
`define PLP_RES_SPAN 16'h0004
`define PLP_RES_MTYPE 16'h0005
`define PLP_RES_LEN 16'h0006

`define PLP_RESP_OKAY 2'h0
`define PLP_RESP_SLVERR 2'h2

`endif

// ==== rtl/plp_pkg.sv ====
// types shared by the parameter load parser files
// assumes plp_cfg.svh on the include path
`include "plp_cfg.svh"

package plp_pkg;

  typedef enum logic [2:0] {
    PLP_IDLE = 3'b000,
    PLP_HDR = 3'b001,
    PLP_CHK = 3'b010,
    PLP_SPEC = 3'b011,
    PLP_DATA = 3'b100,
    PLP_STAT = 3'b101
  } plp_state_t;

  typedef struct packed {
    logic we;
    logic [7:0] mtype;
    logic [15:0] addr;
    logic [15:0] wdata;
  } plp_mem_cmd_t;

  function automatic logic plp_mtype_disc(input logic [7:0] t);
    return (t == `PLP_MT_DISC_IN) || (t == `PLP_MT_DISC_OUT);
  endfunction

  function automatic logic plp_mtype_ok(input logic [7:0] t);
    return plp_mtype_disc(t) || (t == `PLP_MT_REG) || (t == `PLP_MT_AIN) ||
      (t == `PLP_MT_AOUT);
  endfunction

endpackage

// ==== rtl/plp_axil_regs.sv ====
// axi4-lite register slave with sticky event flags and interrupt mask
// assumes a synchronised active-low reset on the same clock as the loader
`timescale 1ns/1ps
`default_nettype none
`include "plp_cfg.svh"

module plp_axil_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic start,
  output logic [7:0] cmd_type,
  output logic [15:0] cmd_off,
  output logic [7:0] tbl_idx,
  input wire logic [31:0] tbl_rdata,
  input wire logic busy,
  input wire logic [15:0] result,
  input wire logic ev_done,
  input wire logic ev_err,
  output logic irq
);
  import plp_pkg::*;

  logic aw_have_q, w_have_q, bvalid_q, rvalid_q, start_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, loc_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q, irq_stat_q, irq_mask_q, clr;
  logic [7:0] idx_q;
  logic do_wr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return old;
  endfunction

  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign arready = !rvalid_q;

  // address and data may arrive in either order; the response waits for both
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (do_wr) begin
        aw_have_q <= 1'b0;
      end else if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (do_wr) begin
        w_have_q <= 1'b0;
      end else if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `PLP_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      unique case (aw_addr_q)
        `PLP_OFF_CTRL, `PLP_OFF_CMD_LOC, `PLP_OFF_STATUS, `PLP_OFF_IRQ_STAT,
        `PLP_OFF_IRQ_MASK, `PLP_OFF_TBL_IDX, `PLP_OFF_TBL_DATA: bresp_q <= `PLP_RESP_OKAY;
        default: bresp_q <= `PLP_RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      loc_q <= `PLP_RST_CMD_LOC;
      irq_mask_q <= `PLP_RST_IRQ_MASK;
      idx_q <= `PLP_RST_TBL_IDX;
    end else begin
      start_q <= do_wr && (aw_addr_q == `PLP_OFF_CTRL) && w_strb_q[0] && w_data_q[0];
      if (do_wr && aw_addr_q == `PLP_OFF_CMD_LOC) begin
        loc_q <= merge(loc_q, w_data_q, w_strb_q);
      end
      if (do_wr && aw_addr_q == `PLP_OFF_IRQ_MASK && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[1:0];
      end
      if (do_wr && aw_addr_q == `PLP_OFF_TBL_IDX && w_strb_q[0]) begin
        idx_q <= w_data_q[7:0];
      end
    end
  end

  assign clr = (do_wr && aw_addr_q == `PLP_OFF_IRQ_STAT && w_strb_q[0]) ? w_data_q[1:0] :
    2'h0;

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= {ev_err, ev_done} | (irq_stat_q & ~clr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PLP_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `PLP_RESP_OKAY;
      unique case (araddr)
        `PLP_OFF_CTRL: rdata_q <= {31'h0, busy};
        `PLP_OFF_CMD_LOC: rdata_q <= loc_q;
        `PLP_OFF_STATUS: rdata_q <= {15'h0, busy, result};
        `PLP_OFF_IRQ_STAT: rdata_q <= {30'h0, irq_stat_q};
        `PLP_OFF_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
        `PLP_OFF_TBL_IDX: rdata_q <= {24'h0, idx_q};
        `PLP_OFF_TBL_DATA: rdata_q <= tbl_rdata;
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `PLP_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign start = start_q;
  assign cmd_type = loc_q[7:0];
  assign cmd_off = loc_q[31:16];
  assign tbl_idx = idx_q;
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

// ==== verif/plp_host_mem.sv ====
// host memory model: word tables and discrete bit tables answering the loader
// assumes requests are held until ack; ack is a one-cycle pulse on clk
`timescale 1ns/1ps
`default_nettype none
module plp_host_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire plp_pkg::plp_mem_cmd_t cmd,
  input wire logic [3:0] dly,
  output logic ack,
  output logic [15:0] rdata
);
  import plp_pkg::*;
  logic [15:0] wm [0:4095];
  logic bm [0:8191];
  logic [3:0] cnt_q;
  function automatic int widx(input logic [7:0] t, input logic [15:0] a);
    return {t[2:1], a[9:0]};
  endfunction
  // discrete word is sixteen bits from offset
  function automatic int bidx(input logic [7:0] t, input logic [15:0] a, input int i);
    return {t[3], 12'(a + 16'(i))};
  endfunction
  task automatic put(input logic [7:0] t, input logic [15:0] a, input logic [15:0] v);
    if (t[6]) begin
      for (int i = 0; i < 16; i++) bm[bidx(t, a, i)] = v[i];
    end else begin
      wm[widx(t, a)] = v;
    end
  endtask
  function automatic logic [15:0] get(input logic [7:0] t, input logic [15:0] a);
    logic [15:0] v;
    if (t[6]) begin
      for (int i = 0; i < 16; i++) v[i] = bm[bidx(t, a, i)];
    end else begin
      v = wm[widx(t, a)];
    end
    return v;
  endfunction
  // plain always: the bench preloads the tables through put
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
      rdata <= 16'h0000;
    end else if (req && !ack && cnt_q == dly) begin
      ack <= 1'b1;
      cnt_q <= 4'h0;
      if (cmd.we) put(cmd.mtype, cmd.addr, cmd.wdata);
      else rdata <= get(cmd.mtype, cmd.addr);
    end else begin
      // released data toggles so a late sample never looks valid
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/parameter_load_command_parser_tb.sv ====
// self-checking bench: axi4-lite master, command blocks in the host model
// assumes plp_param_loader as top and plp_host_mem as host memory
`timescale 1ns/1ps
`default_nettype none
`include "plp_cfg.svh"
module parameter_load_command_parser_tb;
  import plp_pkg::*;
  typedef struct packed {
    logic [7:0] ct, st, dt;
    logic [15:0] co, so, doff, sp, cd, wt, ln, res;
  } plp_row_t;
  // rows: cmd type, status type, data type, cmd off, status off, data off,
  // start, code, blocking flag, header length, result
  // row 1 starts at 240, the last start for a full load
  plp_row_t rows [9] = '{
    '{8'h08, 8'h08, 8'h08, 16'h100, 16'hFF, 16'h200, 16'd1, 16'hE501, 16'd0, 16'd4, 16'd1},
    '{8'h46, 8'h48, 8'h46, 16'h020, 16'h05, 16'h300, 16'd240, 16'hE501, 16'd0, 16'd4, 16'd1},
    '{8'h0A, 8'h0C, 8'h0C, 16'h040, 16'h10, 16'h080, 16'd0, 16'hE501, 16'd0, 16'd4, 16'd1},
    '{8'h08, 8'h08, 8'h08, 16'h100, 16'hFF, 16'h200, 16'd1, 16'hE500, 16'd0, 16'd4, 16'd2},
    '{8'h08, 8'h08, 8'h08, 16'h100, 16'hFF, 16'h200, 16'd1, 16'hE501, 16'd1, 16'd4, 16'd3},
    '{8'h08, 8'h08, 8'h08, 16'h100, 16'hFF, 16'h200, 16'd241, 16'hE501, 16'd0, 16'd4, 16'd4},
    '{8'h08, 8'h08, 8'h09, 16'h100, 16'hFF, 16'h200, 16'd1, 16'hE501, 16'd0, 16'd4, 16'd5},
    '{8'h08, 8'h08, 8'h08, 16'h100, 16'hFF, 16'h200, 16'd1, 16'hE501, 16'd0, 16'd5, 16'd6},
    '{8'h09, 8'h08, 8'h08, 16'h100, 16'hFF, 16'h200, 16'd1, 16'hE501, 16'd0, 16'd4, 16'd5}};
  logic clk, rst_n, awv, wv, bre, arv, rre, mreq, mack, irq;
  logic [7:0] aa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [3:0] dly;
  logic [15:0] mrd;
  plp_mem_cmd_t mcmd;
  logic [31:0] exp_tbl [256];
  int miscompares = 0;
  int n_tests = 0;
  plp_param_loader i_dut (.CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(aa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(), .S_AXI_BRESP(br), .S_AXI_BVALID(),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(), .S_AXI_RREADY(rre),
    .MEM_REQ(mreq), .MEM_CMD(mcmd), .MEM_ACK(mack), .MEM_RDATA(mrd), .IRQ(irq));
  plp_host_mem i_mem (.clk(clk), .rst_n(rst_n), .req(mreq), .cmd(mcmd), .dly(dly),
    .ack(mack), .rdata(mrd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit pa, pw, pb;
    @(posedge clk);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    pa = 1;
    pw = 1;
    pb = 1;
    while (pb) begin
      @(posedge clk);
      if (pa && i_dut.S_AXI_AWREADY) begin
        pa = 0;
        awv <= 1'b0;
      end
      if (pw && i_dut.S_AXI_WREADY) begin
        pw = 0;
        wv <= 1'b0;
      end
      if (i_dut.S_AXI_BVALID) begin
        pb = 0;
        bre <= 1'b0;
        chk(32'(br), 32'(er));
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    bit pa, pb;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    pa = 1;
    pb = 1;
    while (pb) begin
      @(posedge clk);
      if (pa && i_dut.S_AXI_ARREADY) begin
        pa = 0;
        arv <= 1'b0;
      end
      if (i_dut.S_AXI_RVALID) begin
        pb = 0;
        rre <= 1'b0;
        d = rd;
        chk(32'(rr), 32'(er));
      end
    end
  endtask
  function automatic logic [15:0] stp(input logic [7:0] t);
    return t[6] ? 16'h0010 : 16'h0001;
  endfunction
  function automatic logic [15:0] pat(input int n, input int k);
    return {4'(n), 4'hA, 8'(k)};
  endfunction
  task automatic run(input int n);
    plp_row_t r;
    logic [15:0] hd [10];
    logic [31:0] d;
    logic [31:0] ev;
    int w;
    r = rows[n];
    // header as the host builds it
    hd = '{r.ln, r.wt, {8'h00, r.st}, r.so, 16'h0, 16'h0, r.cd, 16'd68, {8'h00, r.dt}, r.doff};
    for (int k = 0; k < 10; k++) i_mem.put(r.ct, r.co + 16'(k) * stp(r.ct), hd[k]);
    i_mem.put(r.dt, r.doff, r.sp);
    i_mem.put(r.dt, r.doff + stp(r.dt), 16'd16);
    for (int k = 0; k < 32; k++) i_mem.put(r.dt, r.doff + 16'(k + 2) * stp(r.dt), pat(n, k));
    if (r.res == 16'd1) begin
      for (int k = 0; k < 16; k++) exp_tbl[8'(r.sp) + 8'(k)] = {pat(n, 2 * k + 1), pat(n, 2 * k)};
    end
    dly <= 4'(n % 3);
    axw(`PLP_OFF_IRQ_MASK, 32'(n % 4), `PLP_RESP_OKAY);
    axw(`PLP_OFF_CMD_LOC, {r.co, 8'h00, r.ct}, `PLP_RESP_OKAY);
    axw(`PLP_OFF_CTRL, 32'h1, `PLP_RESP_OKAY);
    w = 0;
    do begin
      axr(`PLP_OFF_IRQ_STAT, d, `PLP_RESP_OKAY);
      w++;
    end while (d[0] !== 1'b1 && w < 2000);
    ev = {30'h0, r.res != 16'd1, 1'b1};
    chk(d, ev);
    chk(32'(irq), 32'(|(ev[1:0] & 2'(n % 4))));
    axr(`PLP_OFF_STATUS, d, `PLP_RESP_OKAY);
    chk(d, 32'(r.res));
    if (r.ct != 8'h09) chk(32'(i_mem.get(r.st, r.so)), 32'(r.res));
    for (int k = 0; k < 16; k++) begin
      axw(`PLP_OFF_TBL_IDX, 32'(8'(r.sp) + 8'(k)), `PLP_RESP_OKAY);
      axr(`PLP_OFF_TBL_DATA, d, `PLP_RESP_OKAY);
      chk(d, exp_tbl[8'(r.sp) + 8'(k)]);
    end
    axw(`PLP_OFF_IRQ_STAT, 32'h3, `PLP_RESP_OKAY);
    axr(`PLP_OFF_IRQ_STAT, d, `PLP_RESP_OKAY);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test %0d done", n);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    rst_n <= 1'b0;
    {awv, wv, bre, arv, rre} <= 5'h0;
    aa <= 8'h00;
    ara <= 8'h00;
    wd <= 32'h0;
    dly <= 4'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    axr(`PLP_OFF_CMD_LOC, d, `PLP_RESP_OKAY);
    chk(d, `PLP_RST_CMD_LOC);
    for (int n = 0; n < 9; n++) run(n);
    axr(8'h1C, d, `PLP_RESP_SLVERR);
    chk(d, 32'h0);
    axw(8'h1C, 32'h1, `PLP_RESP_SLVERR);
    $display("test unmapped done");
    axw(`PLP_OFF_IRQ_MASK, 32'h3, `PLP_RESP_OKAY);
    axw(`PLP_OFF_CMD_LOC, 32'h0100_0008, `PLP_RESP_OKAY);
    axw(`PLP_OFF_CTRL, 32'h1, `PLP_RESP_OKAY);
    // abort a running load by reset
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({mreq, irq, i_dut.S_AXI_BVALID, i_dut.S_AXI_RVALID}, 32'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    axr(`PLP_OFF_CMD_LOC, d, `PLP_RESP_OKAY);
    chk(d, `PLP_RST_CMD_LOC);
    axr(`PLP_OFF_IRQ_MASK, d, `PLP_RESP_OKAY);
    chk(d, 32'(`PLP_RST_IRQ_MASK));
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
